//--- hdl/dipm_pkg.sv
// Purpose: shared constants for the dual input power mux control
// Assumes: 250 MHz system clock
// Notes: register layout and synchroniser bundle indices
package dipm_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_INPUT_PATH_CTRL = 8'h13;
  localparam int BIT_PATH_TWO_EN = 7;
  localparam int BIT_PATH_ONE_EN = 6;
  localparam int BIT_PAIR_TWO_PRESENT = 2;
  localparam int BIT_PAIR_ONE_PRESENT = 1;
  localparam int BIT_GATE_FORCE_OFF = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // path codes, same encoding as the enable field {two, one}
  localparam logic [1:0] PATH_NONE = 2'h0;
  localparam logic [1:0] PATH_ONE = 2'h1;
  localparam logic [1:0] PATH_TWO = 2'h2;
  localparam logic [1:0] PATH_BOTH = 2'h3;

  // ==========================================================
  // synchroniser bundle
  localparam int SY_W = 7;
  localparam int SY_PIN_ONE = 0;
  localparam int SY_PIN_TWO = 1;
  localparam int SY_VALID_ONE = 2;
  localparam int SY_VALID_TWO = 3;
  localparam int SY_OV_PROT = 4;
  localparam int SY_OC_PROT = 5;
  localparam int SY_BUS_PRESENT = 6;

  typedef enum logic [2:0] {
    ST_DETECT,
    ST_IDLE,
    ST_ON_ONE,
    ST_ON_TWO,
    ST_BREAK
  } dipm_state_t;
endpackage : dipm_pkg

//--- hdl/dipm_sync_if.sv
// Purpose: carrier between the mux control and its synchroniser
// Assumes: one clock domain on the sync side
// Notes: raw is asynchronous, sync is two flops later
`timescale 1ns/1ns
interface dipm_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport snk (input raw, output sync);
endinterface : dipm_sync_if

//--- hdl/dipm_sync.sv
// Purpose: two flop synchroniser bank for pin level inputs
// Assumes: levels only, no pulses shorter than two clocks
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module dipm_sync #(
  parameter int W = 1
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bundle
  dipm_sync_if.snk io
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= io.raw;
      sync_ff <= meta_ff;
    end
  end

  assign io.sync = sync_ff;
endmodule : dipm_sync

//--- hdl/dipm_power_mux.sv
// Purpose: dual input power mux control, gate drives and path register
// Assumes: input valid levels come pre-qualified from the comparators
// Notes: gate pins are released during power-on sensing
//
// Overview of operation
// RULE_01: at power-on sense both gate pins; grounded pins mean no pair, enables locked zero
// RULE_02: with no pairs found both gate drives stay low forever
// RULE_03: only pair one found: presence one set, path two locked off
// RULE_04: single pair: valid input one sets path one enable and turns pair on
// RULE_05: host sets force-off before enabling bus source; this clears path one
// RULE_06: host disables bus source, then clears force-off to reconnect pair one
// RULE_07: both pairs found: both presence bits set, both enables programmable
// RULE_08: two pairs: first valid input wins, later source stays off
// RULE_09: a write enabling both paths at once is ignored; the code still loads force-off from bit 0 of that write
// RULE_10: connected input one invalid with input two valid: swap on its own
// RULE_11: host swaps paths by writing enable field 01b to 10b or back
// RULE_12: after swapping to input two stay there when input one returns
// RULE_13: enable bits read back the real on or off state of pairs
// RULE_14: overvoltage or overcurrent protection turns the pairs off
// RULE_15: single valid input: writing 00b keeps it on, force-off opens both
// RULE_16: both inputs valid: writing 00 or force-off opens both pairs
// RULE_17: on any swap wait for bus below present threshold before next pair
// RULE_18: input validity arrives as one qualified level per sense node
`timescale 1ns/1ns
module dipm_power_mux #(
  parameter int SETTLE_CYCLES = dipm_pkg::SETTLE_CYC
) (
  // clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic SYS_CE_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // gate drive pins
  input wire logic GATE_DRIVE_ONE_I,
  output logic GATE_DRIVE_ONE_O,
  output logic GATE_DRIVE_ONE_OE_N_O,
  input wire logic GATE_DRIVE_TWO_I,
  output logic GATE_DRIVE_TWO_O,
  output logic GATE_DRIVE_TWO_OE_N_O,
  // input qualification
  input wire logic INPUT_SENSE_ONE_VALID_I,
  input wire logic INPUT_SENSE_TWO_VALID_I,
  input wire logic INPUT_OVERVOLTAGE_PROTECT_I,
  input wire logic INPUT_OVERCURRENT_PROTECT_I,
  input wire logic BUS_PRESENT_I,
  // status
  output logic PAIR_ONE_PRESENT_O,
  output logic PAIR_TWO_PRESENT_O,
  output logic CONV_PAUSE_O
);
  // ==========================================================
  // synchronisers
  dipm_sync_if #(.W(dipm_pkg::SY_W)) sy ();

  assign sy.raw[dipm_pkg::SY_PIN_ONE] = GATE_DRIVE_ONE_I;
  assign sy.raw[dipm_pkg::SY_PIN_TWO] = GATE_DRIVE_TWO_I;
  assign sy.raw[dipm_pkg::SY_VALID_ONE] = INPUT_SENSE_ONE_VALID_I; // RULE_18
  assign sy.raw[dipm_pkg::SY_VALID_TWO] = INPUT_SENSE_TWO_VALID_I; // RULE_18
  assign sy.raw[dipm_pkg::SY_OV_PROT] = INPUT_OVERVOLTAGE_PROTECT_I;
  assign sy.raw[dipm_pkg::SY_OC_PROT] = INPUT_OVERCURRENT_PROTECT_I;
  assign sy.raw[dipm_pkg::SY_BUS_PRESENT] = BUS_PRESENT_I;

  dipm_sync #(.W(dipm_pkg::SY_W)) u_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(SYS_CE_I),
    .io(sy.snk)
  );

  // ==========================================================
  // state
  dipm_pkg::dipm_state_t state_ff;
  dipm_pkg::dipm_state_t nxt_state;
  logic [1:0] tgt_ff;
  logic [1:0] nxt_tgt;
  logic hold_ff;
  logic nxt_hold;
  logic [dipm_pkg::CNT_W-1:0] cnt_ff;
  logic [dipm_pkg::CNT_W-1:0] nxt_cnt;
  logic pres_one_ff;
  logic nxt_pres_one;
  logic pres_two_ff;
  logic nxt_pres_two;
  logic force_ff;
  logic nxt_force;
  logic gate_one_ff;
  logic gate_two_ff;
  logic oe_n_ff;
  logic pause_ff;
  logic [7:0] rdata_ff;

  // ==========================================================
  // decode
  wire logic pin_one = sy.sync[dipm_pkg::SY_PIN_ONE];
  wire logic pin_two = sy.sync[dipm_pkg::SY_PIN_TWO];
  wire logic vld_one = sy.sync[dipm_pkg::SY_VALID_ONE];
  wire logic vld_two = sy.sync[dipm_pkg::SY_VALID_TWO];
  wire logic bus_present = sy.sync[dipm_pkg::SY_BUS_PRESENT];
  wire logic prot_fault = sy.sync[dipm_pkg::SY_OV_PROT] | sy.sync[dipm_pkg::SY_OC_PROT];
  wire logic reg_hit = (REG_ADDR_I == dipm_pkg::ADDR_INPUT_PATH_CTRL);
  wire logic wr_ctl = REG_WR_I & reg_hit;
  wire logic rd_ctl = REG_RD_I & reg_hit;
  wire logic [1:0] wr_en = {REG_WDATA_I[dipm_pkg::BIT_PATH_TWO_EN],
                            REG_WDATA_I[dipm_pkg::BIT_PATH_ONE_EN]};
  // an absent pair never qualifies, so its enable stays locked at zero
  wire logic ok_one = pres_one_ff & vld_one; // RULE_02
  wire logic ok_two = pres_two_ff & vld_two; // RULE_02
  wire logic both_vld = vld_one & vld_two;
  wire logic allow = ~nxt_force & ~prot_fault; // RULE_14
  // both-on request falls through every branch below
  wire logic req_one = wr_ctl & (wr_en == dipm_pkg::PATH_ONE); // RULE_09
  wire logic req_two = wr_ctl & (wr_en == dipm_pkg::PATH_TWO); // RULE_09
  wire logic req_off = wr_ctl & (wr_en == dipm_pkg::PATH_NONE);
  wire logic en_one = (state_ff == dipm_pkg::ST_ON_ONE);
  wire logic en_two = (state_ff == dipm_pkg::ST_ON_TWO);

  // force-off is the only stored control bit; presence is read-only
  assign nxt_force = wr_ctl ? REG_WDATA_I[dipm_pkg::BIT_GATE_FORCE_OFF] : force_ff; // RULE_05

  // ==========================================================
  // path selection
  always_comb begin
    nxt_state = state_ff;
    nxt_tgt = tgt_ff;
    nxt_hold = hold_ff & both_vld;
    nxt_cnt = cnt_ff;
    nxt_pres_one = pres_one_ff;
    nxt_pres_two = pres_two_ff;
    unique case (state_ff)
      dipm_pkg::ST_DETECT: begin
        if (cnt_ff == dipm_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
          // a grounded gate pin means no pair fitted
          nxt_pres_one = pin_one; // RULE_01
          nxt_pres_two = pin_two; // RULE_07
          nxt_state = dipm_pkg::ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + dipm_pkg::CNT_W'(1);
        end
      end
      dipm_pkg::ST_IDLE: begin
        if (req_off && both_vld) begin
          nxt_hold = 1'b1; // RULE_16
        end else if (allow && req_one && ok_one) begin
          nxt_hold = 1'b0;
          nxt_state = dipm_pkg::ST_ON_ONE; // RULE_11
        end else if (allow && req_two && ok_two) begin
          nxt_hold = 1'b0;
          nxt_state = dipm_pkg::ST_ON_TWO; // RULE_11
        end else if (allow && !nxt_hold && ok_one) begin
          // input one wins a tie; cleared force-off reconnects here
          nxt_state = dipm_pkg::ST_ON_ONE; // RULE_04 RULE_06 RULE_08
        end else if (allow && !nxt_hold && ok_two) begin
          nxt_state = dipm_pkg::ST_ON_TWO; // RULE_08
        end
      end
      dipm_pkg::ST_ON_ONE: begin
        if (!allow || !ok_one) begin
          // lost input one: fall over to two when it can carry the load
          nxt_tgt = (allow && ok_two) ? dipm_pkg::PATH_TWO : dipm_pkg::PATH_NONE; // RULE_10
          nxt_state = dipm_pkg::ST_BREAK; // RULE_14 RULE_15
        end else if (req_two && ok_two) begin
          nxt_tgt = dipm_pkg::PATH_TWO;
          nxt_state = dipm_pkg::ST_BREAK; // RULE_11
        end else if (req_off && both_vld) begin
          nxt_hold = 1'b1;
          nxt_tgt = dipm_pkg::PATH_NONE;
          nxt_state = dipm_pkg::ST_BREAK; // RULE_16
        end
      end
      dipm_pkg::ST_ON_TWO: begin
        // input one returning does not pull the path back
        if (!allow || !ok_two) begin
          nxt_tgt = (allow && ok_one) ? dipm_pkg::PATH_ONE : dipm_pkg::PATH_NONE;
          nxt_state = dipm_pkg::ST_BREAK; // RULE_14 RULE_15
        end else if (req_one && ok_one) begin
          nxt_tgt = dipm_pkg::PATH_ONE;
          nxt_state = dipm_pkg::ST_BREAK; // RULE_11 RULE_12
        end else if (req_off && both_vld) begin
          nxt_hold = 1'b1;
          nxt_tgt = dipm_pkg::PATH_NONE;
          nxt_state = dipm_pkg::ST_BREAK; // RULE_16
        end
      end
      dipm_pkg::ST_BREAK: begin
        // a host swap written mid-break retargets the pending connection
        if (req_one && ok_one) begin
          nxt_hold = 1'b0;
          nxt_tgt = dipm_pkg::PATH_ONE; // RULE_11
        end else if (req_two && ok_two) begin
          nxt_hold = 1'b0;
          nxt_tgt = dipm_pkg::PATH_TWO; // RULE_11
        end
        // both pairs off until the common node has collapsed
        if (!bus_present) begin // RULE_17
          if (allow && nxt_tgt == dipm_pkg::PATH_ONE && ok_one) begin
            nxt_state = dipm_pkg::ST_ON_ONE;
          end else if (allow && nxt_tgt == dipm_pkg::PATH_TWO && ok_two) begin
            nxt_state = dipm_pkg::ST_ON_TWO;
          end else begin
            nxt_state = dipm_pkg::ST_IDLE;
          end
          nxt_tgt = dipm_pkg::PATH_NONE;
        end
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      state_ff <= dipm_pkg::ST_DETECT;
      tgt_ff <= dipm_pkg::PATH_NONE;
      hold_ff <= 1'b0;
      cnt_ff <= '0;
      pres_one_ff <= 1'b0;
      pres_two_ff <= 1'b0;
      force_ff <= dipm_pkg::CTRL_RESET[dipm_pkg::BIT_GATE_FORCE_OFF];
    end else if (SYS_CE_I) begin
      state_ff <= nxt_state;
      tgt_ff <= nxt_tgt;
      hold_ff <= nxt_hold;
      cnt_ff <= nxt_cnt;
      pres_one_ff <= nxt_pres_one;
      pres_two_ff <= nxt_pres_two;
      force_ff <= nxt_force;
    end
  end

  // ==========================================================
  // pins and status, all from flops
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      gate_one_ff <= 1'b0;
      gate_two_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      pause_ff <= 1'b0;
    end else if (SYS_CE_I) begin
      gate_one_ff <= (nxt_state == dipm_pkg::ST_ON_ONE); // RULE_02 RULE_04
      gate_two_ff <= (nxt_state == dipm_pkg::ST_ON_TWO); // RULE_03
      // pins released only while sensing the straps
      oe_n_ff <= (nxt_state == dipm_pkg::ST_DETECT); // RULE_01
      pause_ff <= (nxt_state == dipm_pkg::ST_BREAK); // RULE_17
    end
  end

  // ==========================================================
  // read path
  wire logic [7:0] rd_word = {en_two, en_one, 3'h0, pres_two_ff, pres_one_ff, force_ff}; // RULE_13

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rdata_ff <= 8'h00;
    end else if (SYS_CE_I && REG_RD_I) begin
      rdata_ff <= rd_ctl ? rd_word : 8'h00;
    end
  end

  assign REG_RDATA_O = rdata_ff;
  assign GATE_DRIVE_ONE_O = gate_one_ff;
  assign GATE_DRIVE_TWO_O = gate_two_ff;
  assign GATE_DRIVE_ONE_OE_N_O = oe_n_ff;
  assign GATE_DRIVE_TWO_OE_N_O = oe_n_ff;
  assign PAIR_ONE_PRESENT_O = pres_one_ff;
  assign PAIR_TWO_PRESENT_O = pres_two_ff;
  assign CONV_PAUSE_O = pause_ff;
endmodule : dipm_power_mux

//--- verif/dipm_power_mux_assertions.sv
// Purpose: port checks for the power mux control
// Assumes: gate pins resolved by the bench
// Notes: bound to every dipm_power_mux
`timescale 1ns/1ns
module dipm_power_mux_assertions (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  // watched ports
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic GATE_DRIVE_ONE_O,
  input wire logic GATE_DRIVE_TWO_O,
  input wire logic GATE_DRIVE_ONE_OE_N_O,
  input wire logic GATE_DRIVE_TWO_OE_N_O,
  input wire logic INPUT_OVERVOLTAGE_PROTECT_I,
  input wire logic INPUT_OVERCURRENT_PROTECT_I,
  input wire logic BUS_PRESENT_I,
  input wire logic PAIR_ONE_PRESENT_O,
  input wire logic PAIR_TWO_PRESENT_O,
  input wire logic CONV_PAUSE_O
);
  // ====================
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  chk_never_both_on: assert property (!(GATE_DRIVE_ONE_O && GATE_DRIVE_TWO_O))
    else $error("both gate drives on");
  chk_one_locked_off: assert property (!PAIR_ONE_PRESENT_O |-> !GATE_DRIVE_ONE_O)
    else $error("gate one on without pair");
  chk_two_locked_off: assert property (!PAIR_TWO_PRESENT_O |-> !GATE_DRIVE_TWO_O)
    else $error("gate two on without pair");
  chk_two_after_bus: assert property ($rose(GATE_DRIVE_TWO_O) |-> !$past(BUS_PRESENT_I, 2))
    else $error("gate two on with bus up");
  chk_one_after_bus: assert property ($rose(GATE_DRIVE_ONE_O) |-> !$past(BUS_PRESENT_I, 2))
    else $error("gate one on with bus up");
  chk_pause_gates_off: assert property (CONV_PAUSE_O |-> !GATE_DRIVE_ONE_O && !GATE_DRIVE_TWO_O)
    else $error("pause with a gate on");
  chk_fault_opens: assert property ((INPUT_OVERVOLTAGE_PROTECT_I || INPUT_OVERCURRENT_PROTECT_I) [*5]
    |-> !GATE_DRIVE_ONE_O && !GATE_DRIVE_TWO_O) else $error("gate on during fault");
  chk_reset_release: assert property (disable iff (1'b0) SYS_RST_I |=> GATE_DRIVE_ONE_OE_N_O
    && GATE_DRIVE_TWO_OE_N_O && !GATE_DRIVE_ONE_O && !PAIR_ONE_PRESENT_O) else $error("reset state");
  chk_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I != 8'h13 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  chk_presence_read: assert property (REG_RD_I && REG_ADDR_I == 8'h13 |=> REG_RDATA_O[5:1] ==
    {3'h0, $past(PAIR_TWO_PRESENT_O), $past(PAIR_ONE_PRESENT_O)}) else $error("status read");
endmodule : dipm_power_mux_assertions

bind dipm_power_mux dipm_power_mux_assertions chk (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .GATE_DRIVE_ONE_O(GATE_DRIVE_ONE_O), .GATE_DRIVE_TWO_O(GATE_DRIVE_TWO_O),
  .GATE_DRIVE_ONE_OE_N_O(GATE_DRIVE_ONE_OE_N_O), .GATE_DRIVE_TWO_OE_N_O(GATE_DRIVE_TWO_OE_N_O),
  .INPUT_OVERVOLTAGE_PROTECT_I(INPUT_OVERVOLTAGE_PROTECT_I), .BUS_PRESENT_I(BUS_PRESENT_I),
  .INPUT_OVERCURRENT_PROTECT_I(INPUT_OVERCURRENT_PROTECT_I), .CONV_PAUSE_O(CONV_PAUSE_O),
  .PAIR_ONE_PRESENT_O(PAIR_ONE_PRESENT_O), .PAIR_TWO_PRESENT_O(PAIR_TWO_PRESENT_O));

//--- verif/dipm_pair_model.sv
// Purpose: external switch pairs and common node
// Assumes: absent pair has its gate pin grounded
// Notes: node falls three clocks after both pairs open
`timescale 1ns/1ns
module dipm_pair_model (
  // clock and fitting
  input wire logic clk_i,
  input wire logic fit_one_i,
  input wire logic fit_two_i,
  // gate pins
  input wire logic drv_one_i,
  input wire logic oe_one_n_i,
  input wire logic drv_two_i,
  input wire logic oe_two_n_i,
  output logic pin_one_o,
  output logic pin_two_o,
  // common node
  output logic bus_o
);
  // ====================
  // pins and node
  logic [2:0] bus_ff = 3'h0;
  // released gate of a fitted pair reads high
  assign pin_one_o = fit_one_i & (oe_one_n_i | drv_one_i);
  assign pin_two_o = fit_two_i & (oe_two_n_i | drv_two_i);
  always @(posedge clk_i) begin
    bus_ff <= {bus_ff[1:0], drv_one_i | drv_two_i};
  end
  assign bus_o = bus_ff[2];
endmodule : dipm_pair_model

//--- verif/test_dual_input_power_mux_control.sv
// Purpose: register level tests of the power mux control
// Assumes: settle count shortened to 4
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_dual_input_power_mux_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, v1 = 1'b0, v2 = 1'b0, ov = 1'b0, oc = 1'b0;
  logic f1 = 1'b0, f2 = 1'b0;
  logic [7:0] rdata;
  logic g1, g2, oe1, oe2, p1, p2, pause, pin1, pin2, bus;
  int fails = 0, tests_run = 0, cyc = 0;
  always #2 clk = ~clk;
  // ====================
  // design and far side
  dipm_power_mux #(.SETTLE_CYCLES(4)) dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .SYS_CE_I(1'b1),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .GATE_DRIVE_ONE_I(pin1), .GATE_DRIVE_ONE_O(g1), .GATE_DRIVE_ONE_OE_N_O(oe1),
    .GATE_DRIVE_TWO_I(pin2), .GATE_DRIVE_TWO_O(g2), .GATE_DRIVE_TWO_OE_N_O(oe2),
    .INPUT_SENSE_ONE_VALID_I(v1), .INPUT_SENSE_TWO_VALID_I(v2),
    .INPUT_OVERVOLTAGE_PROTECT_I(ov), .INPUT_OVERCURRENT_PROTECT_I(oc), .BUS_PRESENT_I(bus),
    .PAIR_ONE_PRESENT_O(p1), .PAIR_TWO_PRESENT_O(p2), .CONV_PAUSE_O(pause));
  dipm_pair_model far (.clk_i(clk), .fit_one_i(f1), .fit_two_i(f2), .drv_one_i(g1),
    .oe_one_n_i(oe1), .drv_two_i(g2), .oe_two_n_i(oe2), .pin_one_o(pin1), .pin_two_o(pin2),
    .bus_o(bus));
  // ====================
  // tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic wr_reg(input logic [7:0] d);
    @(posedge clk) #1;
    addr = 8'h13;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic wait_g(input logic e1, input logic e2);
    int n;
    n = 0;
    while ({g1, g2} !== {e1, e2} && n < 60) begin
      @(posedge clk) #1;
      n++;
    end
    `CHK({g1, g2}, {e1, e2})
  endtask : wait_g
  task automatic stay_g(input logic e1, input logic e2);
    repeat (30) @(posedge clk);
    #1 `CHK({g1, g2}, {e1, e2})
  endtask : stay_g
  task automatic boot(input logic a, input logic b);
    @(posedge clk) #1;
    f1 = a;
    f2 = b;
    rst = 1'b1;
    v1 = 1'b0;
    v2 = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (20) @(posedge clk);
    #1 `CHK({p1, p2}, {a, b})
    `CHK({oe1, oe2}, 2'h0)
  endtask : boot
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  // ====================
  // tests
  initial begin
    boot(1'b0, 1'b0);
    rd_chk(8'h13, 8'h00);
    v1 = 1'b1;
    v2 = 1'b1;
    wr_reg(8'h40);
    stay_g(1'b0, 1'b0);
    rd_chk(8'h14, 8'h00);
    $display("test no_pair done");
    boot(1'b1, 1'b0);
    v1 = 1'b1;
    wait_g(1'b1, 1'b0);
    rd_chk(8'h13, 8'h42);
    wr_reg(8'h80);
    stay_g(1'b1, 1'b0);
    wr_reg(8'h01);
    wait_g(1'b0, 1'b0);
    rd_chk(8'h13, 8'h03);
    wr_reg(8'h00);
    wait_g(1'b1, 1'b0);
    $display("test one_pair done");
    boot(1'b1, 1'b1);
    v2 = 1'b1;
    wait_g(1'b0, 1'b1);
    v1 = 1'b1;
    stay_g(1'b0, 1'b1);
    rd_chk(8'h13, 8'h86);
    wr_reg(8'hc0);
    stay_g(1'b0, 1'b1);
    wr_reg(8'h40);
    @(posedge clk) #1 `CHK(pause, 1'b1)
    wait_g(1'b1, 1'b0);
    rd_chk(8'h13, 8'h46);
    v1 = 1'b0;
    wait_g(1'b0, 1'b1);
    v1 = 1'b1;
    stay_g(1'b0, 1'b1);
    wr_reg(8'h00);
    wait_g(1'b0, 1'b0);
    stay_g(1'b0, 1'b0);
    wr_reg(8'h40);
    wait_g(1'b1, 1'b0);
    ov = 1'b1;
    wait_g(1'b0, 1'b0);
    ov = 1'b0;
    oc = 1'b1;
    stay_g(1'b0, 1'b0);
    oc = 1'b0;
    v2 = 1'b0;
    wait_g(1'b1, 1'b0);
    wr_reg(8'h00);
    stay_g(1'b1, 1'b0);
    wr_reg(8'h01);
    wait_g(1'b0, 1'b0);
    $display("test two_pairs done");
    end_of_test;
  end
endmodule : test_dual_input_power_mux_control
